// file: common/trw_cfg.svh
// timing counts and field constants for the transceiver reconfiguration writer
// assumes a 50 MHz system clock
`ifndef TRW_CFG_SVH
`define TRW_CFG_SVH
`define TRW_CLK_NS 20
`define TRW_WORD_W 16
`define TRW_ADDR_W 8
`define TRW_CHAN_W 2
`define TRW_IMAGE_WORDS 8
`define TRW_OFFSET_CYC 16
`define TRW_SCAN_DIV 2
`define TRW_SCAN_CYC 4
`define TRW_RELOCK_MS 1
`define TRW_RELOCK_CYC (`TRW_RELOCK_MS * 1000000 / `TRW_CLK_NS)
`define TRW_ARESET_NS 10
`define TRW_ARESET_CYC ((`TRW_ARESET_NS + `TRW_CLK_NS - 1) / `TRW_CLK_NS)
`define TRW_PMA_W 4
`endif

// file: common/trw_link_if.sv
// link between the reconfiguration controller and the transceiver/PLL side
// both ends on i_clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "trw_cfg.svh"
interface trw_link_if;
    import trw_pkg::*;
    logic wr_en;
    logic [`TRW_CHAN_W-1:0] chan;
    logic [`TRW_ADDR_W-1:0] addr;
    trw_word_type wdata;
    logic pma_en;
    trw_pma_type output_swing_setting;
    trw_pma_type preemph;
    trw_pma_type dc_gain;
    trw_pma_type equalizer;
    logic scan_clk_en;
    logic scan_data;
    logic scan_en;
    logic scan_done;
    logic pll_locked;
    modport ctrl (output wr_en, chan, addr, wdata, pma_en, output_swing_setting, preemph,
        dc_gain, equalizer, scan_clk_en, scan_data, scan_en, input scan_done, pll_locked);
    modport xcvr (input wr_en, chan, addr, wdata, pma_en, output_swing_setting, preemph,
        dc_gain, equalizer, scan_clk_en, scan_data, scan_en, output scan_done, pll_locked);
endinterface : trw_link_if
`default_nettype wire

// file: common/trw_pkg.sv
// types shared by both ends of the reconfiguration writer
// assumes trw_cfg.svh is on the include path
`include "trw_cfg.svh"
package trw_pkg;
    typedef enum logic [1:0] {TRW_MODE_PMA, TRW_MODE_CHANNEL, TRW_MODE_PLL} trw_mode_type;
    typedef logic [`TRW_WORD_W-1:0] trw_word_type;
    typedef logic [`TRW_PMA_W-1:0] trw_pma_type;
endpackage : trw_pkg

// file: core/trw_controller.sv
// reconfiguration controller: streams image words, PMA settings, PLL scan
// assumes the requester obeys busy and the link peer is on i_clk_sys
// Summary of operation
// RULE_01: channel path issues writes only
// RULE_02: one trigger streams all words in continuous
// RULE_03: image moves as 16-bit words
// RULE_04: channel mode rewrites PCS and RX PMA
// RULE_05: settings come from stored image
// RULE_06: one controller owns each transceiver block
// RULE_07: PMA set: swing, preemphasis, gain, equalizer
// RULE_08: equalizer changes only in PMA mode
// RULE_09: user waits 1 ms for relock
// RULE_10: scan takes about 3.5 scan clocks
// RULE_11: asynchronous clear held at least 10 ns
// RULE_12: busy at offset cancellation and transactions
// RULE_13: trigger only when idle, inputs held
`timescale 1ns/10ps
`default_nettype none
`include "trw_cfg.svh"
module trw_controller
    import trw_pkg::*;
(
    input wire logic i_clk_sys, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_write_all, // bulk write trigger pulse
    input wire logic i_write_one, // single word write pulse
    input wire logic i_continuous, // continuous write select
    input wire trw_mode_type i_mode, // reconfiguration mode
    input wire logic [`TRW_CHAN_W-1:0] i_chan, // target channel
    input wire trw_pma_type i_swing, // output swing request
    input wire trw_pma_type i_preemph, // pre-emphasis request
    input wire trw_pma_type i_dc_gain, // dc gain request
    input wire trw_pma_type i_equalizer, // equalizer request
    input wire logic [`TRW_WORD_W-1:0] i_scan_word, // pll scan pattern
    output logic o_busy, // controller busy
    output logic o_done, // transaction finished pulse
    trw_link_if.ctrl link // link to transceiver side
);
    typedef enum logic [2:0] {ST_OFFSET, ST_IDLE, ST_WRITE, ST_PMA, ST_SCAN} trw_state_type;

    // stored reconfiguration image for the target functional mode
    trw_word_type image [`TRW_IMAGE_WORDS];
    genvar g;
    generate
        for (g = 0; g < `TRW_IMAGE_WORDS; g = g + 1)
        begin : gen_image
            assign image[g] = trw_word_type'(16'hA500 + g);
        end
    endgenerate

    function automatic logic is_last(input logic [`TRW_ADDR_W-1:0] a);
        is_last = (a == `TRW_ADDR_W'(`TRW_IMAGE_WORDS - 1));
    endfunction : is_last

    trw_state_type state, next_state;
    logic [`TRW_ADDR_W-1:0] addr, next_addr;
    logic [`TRW_ADDR_W-1:0] waddr, next_waddr;
    logic [`TRW_ADDR_W-1:0] cnt, next_cnt;
    logic [`TRW_WORD_W-1:0] shreg, next_shreg;
    logic [1:0] div, next_div;
    logic cont, next_cont;
    logic busy, next_busy;
    logic done, next_done;
    logic wr_en, next_wr_en;
    logic [`TRW_CHAN_W-1:0] chan, next_chan;
    trw_word_type wdata, next_wdata;
    logic pma_en, next_pma_en;
    trw_pma_type swing, next_swing, pre, next_pre, gain, next_gain, eq, next_eq;
    logic sclk_en, next_sclk_en, sdata, next_sdata, sen, next_sen;

    always_comb
    begin
        next_state = state;
        next_addr = addr;
        next_waddr = waddr;
        next_cnt = cnt;
        next_shreg = shreg;
        next_div = div;
        next_cont = cont;
        next_done = 1'b0;
        next_wr_en = 1'b0;
        next_chan = chan;
        next_wdata = wdata;
        next_pma_en = 1'b0;
        next_swing = swing;
        next_pre = pre;
        next_gain = gain;
        next_eq = eq;
        next_sclk_en = 1'b0;
        next_sdata = sdata;
        next_sen = 1'b0;
        case (state)
            // RULE_12 offset cancellation busy
            ST_OFFSET:
            begin
                next_cnt = cnt + 1'b1;
                if (cnt == `TRW_ADDR_W'(`TRW_OFFSET_CYC - 1))
                begin
                    next_cnt = '0;
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                next_addr = '0;
                next_cnt = '0;
                // RULE_13 trigger while idle
                if ((i_write_all || i_write_one) && i_mode == TRW_MODE_CHANNEL)
                begin
                    next_cont = i_write_all && i_continuous;
                    // RULE_06 any channel, one owner
                    next_chan = i_chan;
                    next_state = ST_WRITE;
                end
                else if (i_write_all && i_mode == TRW_MODE_PMA)
                begin
                    next_chan = i_chan;
                    next_state = ST_PMA;
                end
                else if (i_write_all && i_mode == TRW_MODE_PLL)
                begin
                    next_shreg = i_scan_word;
                    next_div = '0;
                    next_state = ST_SCAN;
                end
            end
            ST_WRITE:
            begin
                // RULE_01 writes only
                next_wr_en = 1'b1;
                // RULE_03 sixteen bit words
                // RULE_05 from stored image
                next_wdata = image[addr[$clog2(`TRW_IMAGE_WORDS)-1:0]];
                next_waddr = addr;
                next_addr = addr + 1'b1;
                // RULE_02 continuous stream
                if (!cont || is_last(addr))
                begin
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_PMA:
            begin
                // RULE_07 pma control set
                next_pma_en = 1'b1;
                next_swing = i_swing;
                next_pre = i_preemph;
                next_gain = i_dc_gain;
                // RULE_08 equalizer in pma mode
                next_eq = i_equalizer;
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            ST_SCAN:
            begin
                // RULE_10 divided scan clock
                next_sen = 1'b1;
                next_div = div + 1'b1;
                if (div == 2'(`TRW_SCAN_DIV - 1))
                begin
                    next_div = '0;
                    next_sclk_en = 1'b1;
                    next_sdata = shreg[`TRW_WORD_W-1];
                    next_shreg = {shreg[`TRW_WORD_W-2:0], 1'b0};
                    next_cnt = cnt + 1'b1;
                    if (cnt == `TRW_ADDR_W'(`TRW_SCAN_CYC - 1))
                    begin
                        next_done = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        // RULE_12 busy outside idle
        next_busy = (next_state != ST_IDLE);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= ST_OFFSET;
            addr <= '0;
            waddr <= '0;
            cnt <= '0;
            shreg <= '0;
            div <= '0;
            cont <= 1'b0;
            busy <= 1'b1;
            done <= 1'b0;
            wr_en <= 1'b0;
            chan <= '0;
            wdata <= '0;
            pma_en <= 1'b0;
            swing <= '0;
            pre <= '0;
            gain <= '0;
            eq <= '0;
            sclk_en <= 1'b0;
            sdata <= 1'b0;
            sen <= 1'b0;
        end
        else
        begin
            state <= next_state;
            addr <= next_addr;
            waddr <= next_waddr;
            cnt <= next_cnt;
            shreg <= next_shreg;
            div <= next_div;
            cont <= next_cont;
            busy <= next_busy;
            done <= next_done;
            wr_en <= next_wr_en;
            chan <= next_chan;
            wdata <= next_wdata;
            pma_en <= next_pma_en;
            swing <= next_swing;
            pre <= next_pre;
            gain <= next_gain;
            eq <= next_eq;
            sclk_en <= next_sclk_en;
            sdata <= next_sdata;
            sen <= next_sen;
        end
    end

    assign o_busy = busy;
    assign o_done = done;
    assign link.wr_en = wr_en;
    assign link.chan = chan;
    // address of the word on the link, registered beside the data
    assign link.addr = waddr;
    assign link.wdata = wdata;
    assign link.pma_en = pma_en;
    assign link.output_swing_setting = swing;
    assign link.preemph = pre;
    assign link.dc_gain = gain;
    assign link.equalizer = eq;
    assign link.scan_clk_en = sclk_en;
    assign link.scan_data = sdata;
    assign link.scan_en = sen;
endmodule : trw_controller
`default_nettype wire

// file: core/trw_transceiver.sv
// transceiver side: holds channel PCS/RX PMA words, PMA swing and equalizer, PLL scan
// assumes a single controller drives this block over trw_link_if
`timescale 1ns/10ps
`default_nettype none
`include "trw_cfg.svh"
module trw_transceiver
    import trw_pkg::*;
#(
    parameter int RELOCK_CYC = `TRW_RELOCK_CYC
)
(
    input wire logic i_clk_sys, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_pll_areset, // pll asynchronous clear
    output logic [`TRW_WORD_W-1:0] o_last_word, // last word written
    output logic [`TRW_CHAN_W-1:0] o_last_chan, // channel last rewritten
    output logic [`TRW_PMA_W-1:0] o_equalizer, // applied equalizer
    output logic [`TRW_PMA_W-1:0] o_swing, // applied output swing
    trw_link_if.xcvr link // link from controller
);
    logic [`TRW_WORD_W-1:0] last_word, next_last_word, scan_reg, next_scan_reg;
    logic [`TRW_CHAN_W-1:0] last_chan, next_last_chan;
    trw_pma_type eq, next_eq, swing, next_swing;
    logic [31:0] lock_cnt, next_lock_cnt;
    logic locked, next_locked, done, next_done;
    logic [`TRW_ARESET_CYC:0] clr_sh;

    always_comb
    begin
        next_last_word = last_word;
        next_last_chan = last_chan;
        next_eq = eq;
        next_swing = swing;
        next_scan_reg = scan_reg;
        next_done = 1'b0;
        next_lock_cnt = lock_cnt;
        next_locked = locked;
        // RULE_04 pcs and rx pma
        if (link.wr_en)
        begin
            next_last_word = link.wdata;
            next_last_chan = link.chan;
        end
        // RULE_08 equalizer only pma mode
        if (link.pma_en)
        begin
            next_eq = link.equalizer;
            next_swing = link.output_swing_setting;
        end
        if (link.scan_clk_en)
            next_scan_reg = {scan_reg[`TRW_WORD_W-2:0], link.scan_data};
        // RULE_09 relock after scan or clear
        if (link.scan_clk_en || clr_sh[`TRW_ARESET_CYC])
        begin
            next_locked = 1'b0;
            next_lock_cnt = '0;
        end
        else if (!locked)
        begin
            next_lock_cnt = lock_cnt + 1;
            if (lock_cnt == 32'(RELOCK_CYC - 1))
                next_locked = 1'b1;
        end
        next_done = link.scan_en && !locked;
    end

    // RULE_11 clear seen after synchroniser
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            clr_sh <= '0;
        else
            clr_sh <= {clr_sh[`TRW_ARESET_CYC-1:0], i_pll_areset};
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            last_word <= '0;
            last_chan <= '0;
            eq <= '0;
            swing <= '0;
            scan_reg <= '0;
            done <= 1'b0;
            lock_cnt <= '0;
            locked <= 1'b0;
        end
        else
        begin
            last_word <= next_last_word;
            last_chan <= next_last_chan;
            eq <= next_eq;
            swing <= next_swing;
            scan_reg <= next_scan_reg;
            done <= next_done;
            lock_cnt <= next_lock_cnt;
            locked <= next_locked;
        end
    end

    assign o_last_word = last_word;
    assign o_last_chan = last_chan;
    assign o_equalizer = eq;
    assign o_swing = swing;
    assign link.scan_done = done;
    assign link.pll_locked = locked;
endmodule : trw_transceiver
`default_nettype wire

// file: tb/tb.sv
// bench: controller and transceiver joined by trw_link_if, random settings
// assumes package, interface, design and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "trw_cfg.svh"
module tb;
    import trw_pkg::*;
    localparam int RELOCK = 20;
    logic i_clk_sys, i_rst_n, i_write_all, i_write_one, i_continuous, i_pll_areset;
    trw_mode_type i_mode;
    logic [`TRW_CHAN_W-1:0] i_chan, o_last_chan;
    trw_pma_type i_swing, i_preemph, i_dc_gain, i_equalizer, o_equalizer, o_swing, sw, eq;
    logic [`TRW_WORD_W-1:0] i_scan_word, o_last_word;
    logic o_busy, o_done;
    int fail_count, n_compared, n_wr, n_scan;
    logic [3:0] scan_seen;
    trw_link_if link();
    trw_controller u_trw_controller (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_write_all(i_write_all), .i_write_one(i_write_one), .i_continuous(i_continuous),
        .i_mode(i_mode), .i_chan(i_chan), .i_swing(i_swing), .i_preemph(i_preemph),
        .i_dc_gain(i_dc_gain), .i_equalizer(i_equalizer), .i_scan_word(i_scan_word),
        .o_busy(o_busy), .o_done(o_done), .link(link));
    trw_transceiver #(.RELOCK_CYC(RELOCK)) u_trw_transceiver (.i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n), .i_pll_areset(i_pll_areset), .o_last_word(o_last_word),
        .o_last_chan(o_last_chan), .o_equalizer(o_equalizer), .o_swing(o_swing), .link(link));
    trw_link_asserts #(.RELOCK_CYC(RELOCK)) u_trw_link_asserts (.i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n), .wr_en(link.wr_en), .addr(link.addr), .wdata(link.wdata),
        .pma_en(link.pma_en), .output_swing_setting(link.output_swing_setting),
        .equalizer(link.equalizer), .scan_clk_en(link.scan_clk_en), .scan_en(link.scan_en),
        .pll_locked(link.pll_locked));
    initial
    begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys)
    begin
        n_wr <= n_wr + int'(link.wr_en === 1'b1);
        n_scan <= n_scan + int'(link.scan_clk_en === 1'b1);
        if (link.scan_clk_en === 1'b1)
            scan_seen <= {scan_seen[2:0], link.scan_data};
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        n_compared++;
        if (seen !== expd)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask : check
    task automatic end_of_test();
        if (fail_count == 0 && n_compared > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    // one trigger, then a bounded wait for done; ok says whether done is due
    task automatic run(input trw_mode_type m, input logic one, input logic ok);
        int k;
        int lim;
        lim = ok ? 40 : 12;
        @(posedge i_clk_sys);
        i_mode <= m;
        i_write_all <= !one;
        i_write_one <= one;
        #1;
        n_wr = 0;
        n_scan = 0;
        @(posedge i_clk_sys);
        i_write_all <= 1'b0;
        i_write_one <= 1'b0;
        k = 0;
        #1;
        while (o_done !== 1'b1 && k < lim)
        begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        check(16'(k < lim), 16'(ok));
        @(posedge i_clk_sys);
        #1;
    endtask : run
    task automatic wait_lock();
        int k;
        k = 0;
        while (link.pll_locked !== 1'b1 && k < RELOCK + 12)
        begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        check(16'(k < RELOCK + 12), 16'h0001);
    endtask : wait_lock
    initial
    begin
        #400000;
        fail_count++;
        end_of_test();
    end
    initial
    begin
        fail_count = 0;
        n_compared = 0;
        n_wr = 0;
        n_scan = 0;
        void'($urandom(17312));
        {i_rst_n, i_write_all, i_write_one, i_pll_areset} = 4'h0;
        i_continuous = 1'b1;
        i_mode = TRW_MODE_CHANNEL;
        i_chan = 2'h0;
        {i_swing, i_preemph, i_dc_gain, i_equalizer} = 16'h0000;
        i_scan_word = 16'h0000;
        repeat (10) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        #1;
        check(16'(o_busy), 16'h0001);
        run(TRW_MODE_CHANNEL, 1'b0, 1'b0);
        check(16'(n_wr), 16'h0000);
        check(16'(o_busy), 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            @(posedge i_clk_sys);
            i_chan <= 2'(c);
            run(TRW_MODE_CHANNEL, 1'b0, 1'b1);
            check(16'(n_wr), 16'h0008);
            check(o_last_word, 16'hA507);
            check(16'(o_last_chan), 16'(c));
            check(16'(link.chan), 16'(c));
        end
        @(posedge i_clk_sys);
        i_continuous <= 1'b0;
        run(TRW_MODE_CHANNEL, 1'b1, 1'b1);
        check(16'(n_wr), 16'h0001);
        run(TRW_MODE_CHANNEL, 1'b0, 1'b1);
        check(16'(n_wr), 16'h0001);
        run(TRW_MODE_PMA, 1'b1, 1'b0);
        check(16'(n_wr), 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            sw = (i == 0) ? 4'hF : 4'($urandom);
            eq = (i == 0) ? 4'h0 : 4'($urandom);
            @(posedge i_clk_sys);
            i_swing <= sw;
            i_equalizer <= eq;
            i_preemph <= 4'($urandom);
            i_dc_gain <= 4'($urandom);
            i_continuous <= 1'b1;
            run(TRW_MODE_PMA, 1'b0, 1'b1);
            check(16'(o_swing), 16'(sw));
            check(16'(o_equalizer), 16'(eq));
            check(16'({link.preemph, link.dc_gain}), 16'({i_preemph, i_dc_gain}));
            @(posedge i_clk_sys);
            i_equalizer <= ~eq;
            run(TRW_MODE_CHANNEL, 1'b0, 1'b1);
            check(16'(o_equalizer), 16'(eq));
        end
        @(posedge i_clk_sys);
        i_scan_word <= 16'($urandom);
        run(TRW_MODE_PLL, 1'b0, 1'b1);
        check(16'(n_scan), 16'h0004);
        check(16'(scan_seen), 16'(i_scan_word[15:12]));
        check(16'(link.scan_done), 16'h0001);
        wait_lock();
        // clear held one clock, 20 ns
        @(posedge i_clk_sys);
        i_pll_areset <= 1'b1;
        @(posedge i_clk_sys);
        i_pll_areset <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        #1;
        check(16'(link.pll_locked), 16'h0000);
        wait_lock();
        end_of_test();
    end
endmodule : tb
`default_nettype wire

// file: tb/trw_link_asserts.sv
// link checker: image words, burst order, pma strobes, pll scan and relock
// assumes tb instantiates it beside trw_link_if, connected by name
`timescale 1ns/10ps
`default_nettype none
`include "trw_cfg.svh"
module trw_link_asserts
    import trw_pkg::*;
#(
    parameter int RELOCK_CYC = 20
)
(
    input wire logic i_clk_sys, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic wr_en, // channel word strobe
    input wire logic [`TRW_ADDR_W-1:0] addr, // word address
    input wire trw_word_type wdata, // word data
    input wire logic pma_en, // pma strobe
    input wire trw_pma_type output_swing_setting, // swing setting
    input wire trw_pma_type equalizer, // equalizer setting
    input wire logic scan_clk_en, // scan clock enable
    input wire logic scan_en, // scan running
    input wire logic pll_locked // pll lock
);
    localparam int RELOCK_MAX = RELOCK_CYC + 8;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    property p_word_image;
        wr_en |-> wdata == 16'hA500 + 16'(addr);
    endproperty
    a_word_image: assert property (p_word_image) else $error("bad image word");
    property p_addr_range;
        wr_en |-> addr < 8'h08;
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("bad word address");
    property p_burst_order;
        wr_en && $past(wr_en) |-> addr == $past(addr) + 8'h01;
    endproperty
    a_burst_order: assert property (p_burst_order) else $error("burst out of order");
    property p_write_alone;
        wr_en |-> !pma_en && !scan_en;
    endproperty
    a_write_alone: assert property (p_write_alone) else $error("mixed transfer");
    property p_scan_rate;
        scan_clk_en |=> !scan_clk_en;
    endproperty
    a_scan_rate: assert property (p_scan_rate) else $error("scan clock too fast");
    property p_scan_inside;
        scan_clk_en |-> scan_en;
    endproperty
    a_scan_inside: assert property (p_scan_inside) else $error("scan clock outside scan");
    property p_scan_bound;
        $rose(scan_en) |-> ##[1:12] !scan_en;
    endproperty
    a_scan_bound: assert property (p_scan_bound) else $error("scan too long");
    property p_eq_pma;
        !$stable(equalizer) |-> pma_en;
    endproperty
    a_eq_pma: assert property (p_eq_pma) else $error("equalizer moved");
    property p_swing_pma;
        !$stable(output_swing_setting) |-> pma_en;
    endproperty
    a_swing_pma: assert property (p_swing_pma) else $error("swing moved");
    property p_relock_bound;
        $fell(pll_locked) |-> ##[1:RELOCK_MAX] pll_locked;
    endproperty
    a_relock_bound: assert property (p_relock_bound) else $error("relock late");
    property p_relock_hold;
        $fell(pll_locked) |-> !pll_locked [*8];
    endproperty
    a_relock_hold: assert property (p_relock_hold) else $error("relock early");
endmodule : trw_link_asserts
`default_nettype wire
